// ==== src/edge_monostable_period_timer.sv ====
// period timer with prescaler, postscaler and edge-started one-shot.
// assumes the external reset input and register strobes are synchronous
// to i_mclk; read data appear one cycle after the read strobe.
`timescale 1ns/1ps
module edge_monostable_period_timer
    import edge_monostable_period_timer_pkg::*;
(
    // clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rstn,
    // register port
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    // external trigger
    input  wire logic       i_external_reset_input,
    // timer outputs
    output logic      [7:0] o_timer_count,
    output logic            o_timer_on,
    output logic            o_period_match,
    output logic            o_postscaled_match_output,
    output logic            o_pwm_restart
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic is_oneshot(input logic [4:0] mode);
        is_oneshot = (mode == MODE_ONESHOT_RISE) ||
                     (mode == MODE_ONESHOT_FALL) ||
                     (mode == MODE_ONESHOT_BOTH);
    endfunction

    function automatic logic edge_hit(input logic [4:0] mode,
                                      input logic       prev,
                                      input logic       cur);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = prev & ~cur;
        edge_hit = ((mode == MODE_ONESHOT_RISE) & rise) |
                   ((mode == MODE_ONESHOT_FALL) & fall) |
                   ((mode == MODE_ONESHOT_BOTH) & (rise | fall));
    endfunction

    // low bits of the prescale counter that must all be ones for a tick
    function automatic logic [6:0] prescale_mask(input logic [2:0] sel);
        prescale_mask = 7'((8'h01 << sel) - 8'h01);
    endfunction

    // status word: run in progress and armed-but-idle flags
    function automatic logic [7:0] status_word(input logic run,
                                               input logic armed);
        status_word                  = 8'h00;
        status_word[STATUS_RUN_BIT]  = run;
        status_word[STATUS_WAIT_BIT] = armed;
    endfunction

    // one count step; eight bits wide so the wrap past 8'hff is intended
    function automatic logic [7:0] count_up(input logic [7:0] count);
        count_up = count + 8'h01;
    endfunction

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    logic [7:0] control_reg;
    logic [7:0] control_next;
    logic [7:0] period_reg;
    logic [7:0] period_next;
    logic [4:0] mode_reg;
    logic [4:0] mode_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    logic       shot_done;
    logic       timer_on;
    logic [2:0] ckps;
    logic [3:0] outps;

    shot_state_e state_reg;
    shot_state_e state_next;
    logic [7:0]  count_reg;
    logic [7:0]  count_next;

    assign timer_on = control_reg[ON_BIT];
    assign ckps     = control_reg[CKPS_MSB:CKPS_LSB];
    assign outps    = control_reg[OUTPS_MSB:OUTPS_LSB];

    always_comb begin
        control_next = control_reg;
        period_next  = period_reg;
        mode_next    = mode_reg;
        // hardware clear first, so a software set in the same cycle wins
        if (shot_done) begin
            control_next[ON_BIT] = 1'b0;
        end
        if (i_wr) begin
            unique case (i_addr)
                TIMER_CONTROL_OFFSET: control_next = i_wdata;
                PERIOD_VALUE_OFFSET:  period_next  = i_wdata;
                MODE_SELECT_OFFSET:   mode_next    = i_wdata[4:0];
                // count and status are read-only; writes there drop
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            control_reg <= TIMER_CONTROL_RESET;
            period_reg  <= PERIOD_VALUE_RESET;
            mode_reg    <= MODE_SELECT_RESET;
        end else begin
            control_reg <= control_next;
            period_reg  <= period_next;
            mode_reg    <= mode_next;
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    // read data live one cycle and fall back to zero, so a stale word
    // is never mistaken for a fresh answer
    always_comb begin
        rdata_next = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                TIMER_CONTROL_OFFSET: rdata_next = control_reg;
                PERIOD_VALUE_OFFSET:  rdata_next = period_reg;
                MODE_SELECT_OFFSET:   rdata_next = {3'h0, mode_reg};
                TIMER_COUNT_OFFSET:   rdata_next = count_reg;
                STATUS_OFFSET:        rdata_next = status_word(
                    state_reg == SHOT_RUN,
                    timer_on & is_oneshot(mode_reg) &
                    (state_reg == SHOT_IDLE));
                default:              rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // trigger edge detect
    // ------------------------------------------------------------------
    // previous level resets to the idle low of the line, so leaving reset
    // shows no false edge; the line is sampled every cycle, armed or not,
    // so a level standing before arming is never taken as an edge
    logic ext_prev_reg;
    logic ext_prev_next;

    always_comb begin
        ext_prev_next = i_external_reset_input;
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            ext_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= ext_prev_next;
        end
    end

    // ------------------------------------------------------------------
    // prescaler, counter and one-shot sequencing
    // ------------------------------------------------------------------
    logic [6:0] presc_reg;
    logic [6:0] presc_next;
    logic       match_reg;
    logic       match_next;
    logic       restart_reg;
    logic       restart_next;

    logic       oneshot;
    logic       start_edge;
    logic       counting;
    logic       tick;
    logic       at_period;

    assign oneshot    = is_oneshot(mode_reg);
    // edges only matter while armed and idle
    assign start_edge = timer_on & oneshot & (state_reg == SHOT_IDLE) &
                        edge_hit(mode_reg, ext_prev_reg,
                                 i_external_reset_input);
    assign counting   = timer_on & (!oneshot || state_reg == SHOT_RUN);
    // a tick needs every masked prescale bit set; code 000 ticks always
    assign tick       = counting &
                        ((presc_reg & prescale_mask(ckps)) ==
                         prescale_mask(ckps));
    // equality only: a period lowered below the live count mid-run is
    // missed until the count wraps past zero
    assign at_period  = (count_reg == period_reg);
    assign shot_done  = oneshot & (state_reg == SHOT_RUN) & tick &
                        at_period;

    // one process serves off, one-shot and free-run: a single writer
    always_comb begin
        state_next   = state_reg;
        count_next   = count_reg;
        presc_next   = presc_reg;
        match_next   = 1'b0;
        restart_next = 1'b0;
        if (!timer_on) begin
            // off: everything back to its reset state
            state_next = SHOT_IDLE;
            count_next = TIMER_COUNT_RESET;
            presc_next = PRESCALE_RESET;
        end else if (oneshot) begin
            // a mode write takes effect at once, even in mid-run
            unique case (state_reg)
                SHOT_IDLE: begin
                    // prescaler restarts with each run, so the first tick
                    // lands a full prescale period after the edge
                    presc_next = PRESCALE_RESET;
                    count_next = TIMER_COUNT_RESET;
                    if (start_edge) begin
                        state_next   = SHOT_RUN;
                        restart_next = 1'b1;
                    end
                end
                SHOT_RUN: begin
                    presc_next = presc_reg + 7'h01;
                    if (tick) begin
                        if (at_period) begin
                            // hold the count; enable drops next cycle
                            state_next = SHOT_IDLE;
                            match_next = 1'b1;
                        end else begin
                            count_next = count_up(count_reg);
                        end
                    end
                end
            endcase
        end else begin
            // free-running period mode for every other code
            presc_next = presc_reg + 7'h01;
            if (tick) begin
                if (at_period) begin
                    count_next   = TIMER_COUNT_RESET;
                    match_next   = 1'b1;
                    restart_next = 1'b1;
                end else begin
                    count_next = count_up(count_reg);
                end
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg    <= SHOT_IDLE;
            count_reg    <= TIMER_COUNT_RESET;
            presc_reg    <= PRESCALE_RESET;
            match_reg    <= 1'b0;
            restart_reg  <= 1'b0;
        end else begin
            state_reg    <= state_next;
            count_reg    <= count_next;
            presc_reg    <= presc_next;
            match_reg    <= match_next;
            restart_reg  <= restart_next;
        end
    end

    // ------------------------------------------------------------------
    // postscaler
    // ------------------------------------------------------------------
    // cleared with the enable so a new run starts a fresh ratio; the
    // match of the last one-shot tick still passes while it clears when outps is 0
    edge_postscaler edge_postscaler_inst (
        .i_mclk  (i_mclk),
        .i_rstn  (i_rstn),
        .i_clear (~timer_on),
        .i_ratio (outps),
        .i_match (match_reg),
        .o_pulse (o_postscaled_match_output)
    );

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign o_rdata        = rdata_reg;
    assign o_timer_count  = count_reg;
    assign o_timer_on     = timer_on;
    // both pulses come straight from flip-flops and last one cycle, except free-run at period 0 with prescale 1:1, where they stay high
    assign o_period_match = match_reg;
    assign o_pwm_restart  = restart_reg;

endmodule

// ==== src/edge_monostable_period_timer_pkg.sv ====
// constants shared by the edge-triggered monostable period timer.
// assumes a single 50 MHz clock and a plain strobed register port.
package edge_monostable_period_timer_pkg;

    // --------------------------------------------------------------
    // register offsets
    // --------------------------------------------------------------
    localparam logic [2:0] TIMER_CONTROL_OFFSET = 3'h0;
    localparam logic [2:0] PERIOD_VALUE_OFFSET  = 3'h1;
    localparam logic [2:0] MODE_SELECT_OFFSET   = 3'h2;
    localparam logic [2:0] TIMER_COUNT_OFFSET   = 3'h3;
    localparam logic [2:0] STATUS_OFFSET        = 3'h4;

    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int ON_BIT          = 7;
    localparam int CKPS_MSB        = 6;
    localparam int CKPS_LSB        = 4;
    localparam int OUTPS_MSB       = 3;
    localparam int OUTPS_LSB       = 0;
    localparam int STATUS_RUN_BIT  = 0;
    localparam int STATUS_WAIT_BIT = 1;

    // --------------------------------------------------------------
    // reset values
    // --------------------------------------------------------------
    localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
    localparam logic [7:0] PERIOD_VALUE_RESET  = 8'hff;
    localparam logic [4:0] MODE_SELECT_RESET   = 5'h00;
    localparam logic [7:0] TIMER_COUNT_RESET   = 8'h00;
    localparam logic [6:0] PRESCALE_RESET      = 7'h00;

    // --------------------------------------------------------------
    // mode codes
    // --------------------------------------------------------------
    localparam logic [4:0] MODE_ONESHOT_RISE = 5'h11;
    localparam logic [4:0] MODE_ONESHOT_FALL = 5'h12;
    localparam logic [4:0] MODE_ONESHOT_BOTH = 5'h13;

    typedef enum logic [0:0] {
        SHOT_IDLE,
        SHOT_RUN
    } shot_state_e;

endpackage

// ==== src/edge_postscaler.sv ====
// output postscaler: passes one in every ratio+1 period matches.
// assumes i_clear is held while the timer is off.
`timescale 1ns/1ps
module edge_postscaler
    import edge_monostable_period_timer_pkg::*;
(
    // clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rstn,
    // control
    input  wire logic       i_clear,
    input  wire logic [3:0] i_ratio,
    // match in, divided match out
    input  wire logic       i_match,
    output logic            o_pulse
);

    logic [3:0] div_reg;
    logic [3:0] div_next;
    logic       pulse_reg;
    logic       pulse_next;

    always_comb begin
        div_next   = div_reg;
        pulse_next = 1'b0;
        // a match still passes in the cycle the timer switches off, so
        // the final match of a one-shot run reaches the output when i_ratio is 0
        if (i_match) begin
            if (div_reg >= i_ratio) begin
                div_next   = 4'h0;
                pulse_next = 1'b1;
            end else begin
                div_next = div_reg + 4'h1;
            end
        end
        if (i_clear) begin
            div_next = 4'h0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            div_reg   <= 4'h0;
            pulse_reg <= 1'b0;
        end else begin
            div_reg   <= div_next;
            pulse_reg <= pulse_next;
        end
    end

    assign o_pulse = pulse_reg;

endmodule

// ==== tb/trig_pwm_partner.sv ====
// trigger source and pwm-start listener facing the timer.
// assumes toggle requests are synchronous to i_mclk.
`timescale 1ns/1ps
module trig_pwm_partner (
    // clock and reset
    input  wire logic i_mclk,
    input  wire logic i_rstn,
    // bench request and timer output
    input  wire logic i_toggle,
    input  wire logic i_pwm_restart,
    // trigger line and observed pwm starts
    output logic      o_line,
    output int        o_starts
);
    // push-pull driven line, so it always shows a real level
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_line   <= 1'b0;
            o_starts <= 0;
        end else begin
            o_line   <= o_line ^ i_toggle;
            o_starts <= o_starts + int'(i_pwm_restart);
        end
    end
endmodule

// ==== tb/edge_monostable_period_timer_props.sv ====
// port-level checks for the edge-started one-shot period timer.
// assumes register writes are the only way settings change.
`timescale 1ns/1ps
module edge_monostable_period_timer_props
    import edge_monostable_period_timer_pkg::*;
(
    input wire logic       i_mclk,
    input wire logic       i_rstn,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic       i_external_reset_input,
    input wire logic [7:0] o_timer_count,
    input wire logic       o_timer_on,
    input wire logic       o_period_match,
    input wire logic       o_postscaled_match_output,
    input wire logic       o_pwm_restart
);
    logic [4:0] mode_reg;
    logic [7:0] period_reg;
    logic [7:0] ctl_reg;
    logic       run_reg;
    logic       shot;
    logic       ctl_wr;
    assign shot = mode_reg inside {MODE_ONESHOT_RISE, MODE_ONESHOT_FALL,
                                   MODE_ONESHOT_BOTH};
    assign ctl_wr = i_wr && i_addr == TIMER_CONTROL_OFFSET;
    // shadow of settings, mirrored from the write strobes
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            mode_reg   <= MODE_SELECT_RESET;
            period_reg <= PERIOD_VALUE_RESET;
            ctl_reg    <= TIMER_CONTROL_RESET;
            run_reg    <= 1'b0;
        end else begin
            if (i_wr && i_addr == MODE_SELECT_OFFSET)
                mode_reg <= i_wdata[4:0];
            if (i_wr && i_addr == PERIOD_VALUE_OFFSET)
                period_reg <= i_wdata;
            if (ctl_wr)
                ctl_reg <= i_wdata;
            run_reg <= o_pwm_restart || (run_reg && o_timer_on
                                         && !o_period_match);
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    a_start_needs_on: assert property (o_pwm_restart |-> $past(o_timer_on))
        else $error("pwm start while timer off");
    a_idle_count_zero: assert property (shot && o_timer_on && !run_reg
        && !o_pwm_restart |-> o_timer_count == 8'h00)
        else $error("one-shot counted before its edge");
    a_run_ignores_edge: assert property (shot && run_reg |-> !o_pwm_restart)
        else $error("pwm restarted during a run");
    a_match_no_restart: assert property (shot && o_period_match
        |-> !o_pwm_restart) else $error("pwm restarted on match");
    a_shot_end_off: assert property (shot && o_period_match && !ctl_wr
        |=> !o_timer_on) else $error("enable not cleared after run");
    a_stop_at_period: assert property (shot && o_period_match
        |-> o_timer_count == period_reg) else $error("run ended off period");
    a_prescale_gap: assert property (ctl_reg[6:4] != 3'h0
        && $changed(o_timer_count) |=> $stable(o_timer_count))
        else $error("count stepped on adjacent cycles");
    a_post_follows: assert property (o_postscaled_match_output
        |-> $past(o_period_match)) else $error("postscaled without match");
    a_post_unity: assert property (ctl_reg[3:0] == 4'h0
        && o_period_match |=> o_postscaled_match_output)
        else $error("1:1 postscaler dropped a match");
    a_off_clears: assert property (!o_timer_on && !$past(o_timer_on)
        |-> o_timer_count == 8'h00 && !o_period_match)
        else $error("counter active while off");
    a_on_readback: assert property ($past(i_rd)
        && $past(i_addr) == TIMER_CONTROL_OFFSET
        |-> o_rdata[ON_BIT] == $past(o_timer_on))
        else $error("enable bit read back wrong");
endmodule

// ==== tb/edge_monostable_period_timer_tb_top.sv ====
// register-level bench for the edge-started one-shot period timer.
// assumes one 50 MHz clock and a trigger partner on the reset input.
`timescale 1ns/1ps
module edge_monostable_period_timer_tb_top
    import edge_monostable_period_timer_pkg::*;
;
    logic       i_mclk, i_rstn, i_wr, i_rd, i_toggle, line;
    logic [2:0] i_addr;
    logic [7:0] i_wdata, o_rdata, o_timer_count;
    logic       o_timer_on, o_period_match, o_post, o_pwm_restart;
    int         starts, n_errors = 0, checks_done = 0, cycles = 0, n;
    int         n_post [3] = '{0, 2, 15};
    edge_monostable_period_timer edge_monostable_period_timer_inst (
        .i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_external_reset_input(line), .o_timer_count(o_timer_count),
        .o_timer_on(o_timer_on), .o_period_match(o_period_match),
        .o_postscaled_match_output(o_post), .o_pwm_restart(o_pwm_restart));
    trig_pwm_partner trig_pwm_partner_inst (.i_mclk(i_mclk), .i_rstn(i_rstn),
        .i_toggle(i_toggle), .i_pwm_restart(o_pwm_restart), .o_line(line),
        .o_starts(starts));
    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end
    task automatic results();
        if (n_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // a hang ends the run well past the expected run of under two thousand cycles
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            results();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // ------------------------------------------------------------
    // bus and trigger tasks, each ends just after an edge
    // ------------------------------------------------------------
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        i_addr <= a; i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(posedge i_mclk);
        chk("rdata", {8'h00, e}, {8'h00, o_rdata});
        #1;
    endtask
    task automatic tgl(input int w);
        i_toggle <= 1'b1;
        @(posedge i_mclk);
        i_toggle <= 1'b0;
        #1;
        repeat (w) @(posedge i_mclk);
        #1;
    endtask
    task automatic gap(input bit post);
        repeat (2) begin
            n = 0;
            do begin
                @(posedge i_mclk);
                #1;
                n++;
            end while ((post ? o_post : o_period_match) !== 1'b1 && n < 600);
        end
    endtask
    task automatic shot(input logic [4:0] m);
        int s0;
        s0 = starts;
        wr(MODE_SELECT_OFFSET, {3'h0, m});
        rd(MODE_SELECT_OFFSET, {3'h0, m});
        wr(TIMER_CONTROL_OFFSET, 8'h90); // re-arm, prescale 1:2
        rd(STATUS_OFFSET, 8'h02);
        tgl(4);
        chk("early start", 16'(m != MODE_ONESHOT_FALL), 16'(starts - s0));
        if (m == MODE_ONESHOT_FALL)
            tgl(4);
        rd(STATUS_OFFSET, 8'h01);
        tgl(2);
        tgl(30);
        chk("starts", 16'h0001, 16'(starts - s0));
        chk("on cleared", 16'h0000, {15'h0000, o_timer_on});
        rd(TIMER_CONTROL_OFFSET, 8'h10);
        rd(TIMER_COUNT_OFFSET, 8'h00);
        tgl(3);
        tgl(3);
        chk("starts idle", 16'h0001, 16'(starts - s0));
        if (line)
            tgl(1);
    endtask
    initial begin
        i_rstn = 1'b0; i_wr = 1'b0; i_rd = 1'b0; i_toggle = 1'b0;
        i_addr = 3'h0; i_wdata = 8'h00;
        repeat (20) @(posedge i_mclk);
        i_rstn <= 1'b1;
        @(posedge i_mclk);
        #1;
        rd(TIMER_CONTROL_OFFSET, TIMER_CONTROL_RESET);
        rd(PERIOD_VALUE_OFFSET, PERIOD_VALUE_RESET);
        rd(3'h7, 8'h00);
        wr(TIMER_COUNT_OFFSET, 8'h55);
        rd(TIMER_COUNT_OFFSET, 8'h00);
        wr(PERIOD_VALUE_OFFSET, 8'h01);
        for (int p = 0; p < 8; p++) begin
            wr(TIMER_CONTROL_OFFSET, 8'h00);
            wr(TIMER_CONTROL_OFFSET, 8'h80 | 8'(p << 4));
            gap(1'b0);
            chk("match gap", 16'(2 << p), 16'(n));
        end
        foreach (n_post[i]) begin
            wr(TIMER_CONTROL_OFFSET, 8'h00);
            wr(TIMER_CONTROL_OFFSET, 8'h80 | 8'(n_post[i]));
            gap(1'b1);
            chk("post gap", 16'(2 * (n_post[i] + 1)), 16'(n));
        end
        wr(PERIOD_VALUE_OFFSET, 8'hff);
        repeat (40) @(posedge i_mclk);
        #1;
        wr(TIMER_CONTROL_OFFSET, 8'h00);
        repeat (2) @(posedge i_mclk);
        #1;
        chk("count off", 16'h0000, {8'h00, o_timer_count});
        wr(PERIOD_VALUE_OFFSET, 8'h05);
        shot(MODE_ONESHOT_RISE);
        shot(MODE_ONESHOT_FALL);
        shot(MODE_ONESHOT_BOTH);
        results();
    end
endmodule
bind edge_monostable_period_timer edge_monostable_period_timer_props
    edge_monostable_period_timer_props_inst (.i_mclk(i_mclk),
    .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata),
    .i_external_reset_input(i_external_reset_input),
    .o_timer_count(o_timer_count), .o_timer_on(o_timer_on),
    .o_period_match(o_period_match),
    .o_postscaled_match_output(o_postscaled_match_output),
    .o_pwm_restart(o_pwm_restart));
